// >>> motor_cfg_pkg.sv
/*
 * Shared constants and carriers for the motor controller serial configuration port.
 * Assumes a single sys_clk domain for the core and a separate serial link clock.
 */
package motor_cfg_pkg;

    // ------------------------------------------------------------
    // configuration word layout
    // ------------------------------------------------------------
    localparam int WORD_BITS        = 24;
    localparam int DIR_POS          = 2;
    localparam int ILIM_HI_POS      = 3;
    localparam int ILIM_LO_POS      = 4;
    localparam int SPEED_FIRST_POS  = 5;
    localparam int SPEED_LAST_POS   = 18;
    localparam int SPEED_BITS       = SPEED_LAST_POS - SPEED_FIRST_POS + 1;
    localparam int SECTOR_POS       = 19;
    localparam int DIAG_LO_POS      = 20;
    localparam int DIAG_HI_POS      = 21;
    localparam int BRAKE_POS        = 22;
    localparam int RUN_POS          = 23;
    localparam logic [WORD_BITS-1:0] WORD_RESET = 24'h000000;
    localparam int BITCNT_W         = 5;
    localparam logic [BITCNT_W-1:0] BITCNT_RESET = 5'h00;
    localparam int SPEED_CNT_W      = 20;
    localparam logic [SPEED_CNT_W-1:0] SPEED_CNT_RESET = 20'h00000;

    // ------------------------------------------------------------
    // diagnostic output selector codes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DIAG_THERMAL = 2'h0,
        DIAG_ZCROSS  = 2'h1,
        DIAG_REV     = 2'h2,
        DIAG_SYNC    = 2'h3
    } diag_sel_t;

    // current-limit codes: 00 1.2 A, 01 1.0 A, 10 0.6 A, 11 250 mA
    typedef enum logic [1:0] {
        ILIM_1A2  = 2'h0,
        ILIM_1A0  = 2'h1,
        ILIM_0A6  = 2'h2,
        ILIM_250M = 2'h3
    } ilim_t;

    typedef struct packed {
        logic      run;
        logic      brake;
        diag_sel_t diag_sel;
        logic      sector_mode;
        logic [SPEED_BITS-1:0] speed_count;
        ilim_t     current_limit;
        logic      direction_bit;
    } cfg_t;

    typedef struct packed {
        logic high_a;
        logic high_b;
        logic high_c;
        logic low_a;
        logic low_b;
        logic low_c;
    } drive_t;

    typedef enum logic [5:0] {
        PH0 = 6'b000001,
        PH1 = 6'b000010,
        PH2 = 6'b000100,
        PH3 = 6'b001000,
        PH4 = 6'b010000,
        PH5 = 6'b100000
    } phase_t;

    localparam phase_t PHASE_RESET = PH0;

endpackage

// >>> motor_cfg_port.sv
/*
 * Serial configuration port plus the digital logic it steers directly:
 * commutation order, current-limit code, speed reference counter, diag mux, brake.
 * Assumes analog sensing, comparator events and oscillator edges arrive on core pins.
 */
`timescale 1ns/100ps

// Summary of operation
// [R1] Capture one data bit per rising serial clock edge.
// [R2] Host keeps chip select low across the whole word.
// [R3] Host keeps serial clock low whenever chip select changes.
// [R4] Reset low forces sleep mode.
// [R5] Reset low clears all port bits to zero.
// [R6] Two-bit selector routes thermal, zero-cross, revolution or sync to diag pin.
// [R7] Current-limit code 00/01/10/11 selects 1.2 A, 1.0 A, 0.6 A, 250 mA.
// [R8] Brake low turns on all three low-side drivers.
// [R9] Speed reference counter runs on oscillator edges, not serial clock.
// [R10] Sector input can serve as speed feedback for the loop.
// [R11] Direction bit picks forward or reverse six-state commutation order.
// [R12] Reference length is sum of weights of speed bits programmed zero.
// [R13] Zero-cross toggle flips at every detected back-EMF crossing.
// [R14] Shifted word takes effect whole when chip select rises.
// [R15] Unwritten bits stay cleared; outputs sleep until a word sets the run bit.
module motor_cfg_port (
    input  wire logic                         sys_clk,
    input  wire logic                         rstn,
    input  wire logic                         clk_en,
    input  wire logic                         port_clk,
    input  wire logic                         chip_sel_n,
    input  wire logic                         data_in,
    input  wire logic                         osc_in,
    input  wire logic                         sector_in,
    input  wire logic                         brake_n,
    input  wire logic                         zero_cross_evt,
    input  wire logic                         commutate_evt,
    input  wire logic                         thermal_shutdown,
    input  wire logic                         sync_flag,
    output logic                              sleep,
    output motor_cfg_pkg::drive_t             drive,
    output motor_cfg_pkg::ilim_t              current_limit,
    output logic                              diag_out,
    output logic                              speed_ref,
    output logic                              revolution_pulse,
    output logic                              zero_cross_toggle
);
    import motor_cfg_pkg::*;

    // ------------------------------------------------------------
    // link domain: shift register and word latch
    // ------------------------------------------------------------
    logic [WORD_BITS-1:0] shift_q;
    logic [WORD_BITS-1:0] word_q;
    logic                 word_tgl_q;

    always_ff @(posedge port_clk or negedge rstn) begin
        if (!rstn) begin
            shift_q <= WORD_RESET;                              // see [R5]
        end else if (!chip_sel_n) begin
            shift_q <= {shift_q[WORD_BITS-2:0], data_in};       // see [R1]
        end
    end

    // chip select rising closes the frame; clock is low then by host contract
    always_ff @(posedge chip_sel_n or negedge rstn) begin
        if (!rstn) begin
            word_q     <= WORD_RESET;                           // see [R5]
            word_tgl_q <= 1'b0;
        end else begin
            word_q     <= shift_q;                              // see [R14] see [R3]
            word_tgl_q <= ~word_tgl_q;
        end
    end

    // ------------------------------------------------------------
    // crossing into sys_clk: toggle handshake, then word sampled stable
    // ------------------------------------------------------------
    logic [2:0] tgl_sync_q;
    logic [1:0] osc_sync_q;
    logic [1:0] sec_sync_q;
    logic [1:0] brk_sync_q;
    logic [1:0] zc_sync_q;
    logic       osc_prev_q;
    logic       sec_prev_q;
    logic       zc_prev_q;
    cfg_t       cfg_q;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tgl_sync_q <= 3'h0;
            osc_sync_q <= 2'h0;
            sec_sync_q <= 2'h0;
            brk_sync_q <= 2'h3;
            zc_sync_q  <= 2'h0;
            osc_prev_q <= 1'b0;
            sec_prev_q <= 1'b0;
            zc_prev_q  <= 1'b0;
        end else if (clk_en) begin
            tgl_sync_q <= {tgl_sync_q[1:0], word_tgl_q};
            osc_sync_q <= {osc_sync_q[0], osc_in};
            sec_sync_q <= {sec_sync_q[0], sector_in};
            brk_sync_q <= {brk_sync_q[0], brake_n};
            zc_sync_q  <= {zc_sync_q[0], zero_cross_evt};
            osc_prev_q <= osc_sync_q[1];
            sec_prev_q <= sec_sync_q[1];
            zc_prev_q  <= zc_sync_q[1];
        end
    end

    wire word_new  = tgl_sync_q[2] ^ tgl_sync_q[1];
    wire osc_rise  = osc_sync_q[1] & ~osc_prev_q;                // see [R9]
    wire sec_rise  = sec_sync_q[1] & ~sec_prev_q;
    wire zc_rise   = zc_sync_q[1] & ~zc_prev_q;
    wire brake_on  = ~brk_sync_q[1];

    // word bits to config fields; current-limit code msb is the lower word bit
    cfg_t word_cfg;
    assign word_cfg = {word_q[RUN_POS], word_q[BRAKE_POS], word_q[DIAG_HI_POS], word_q[DIAG_LO_POS],
                       word_q[SECTOR_POS], word_q[SPEED_LAST_POS:SPEED_FIRST_POS],
                       word_q[ILIM_HI_POS], word_q[ILIM_LO_POS], word_q[DIR_POS]};   // see [R7]

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cfg_q <= cfg_t'(WORD_RESET[WORD_BITS-1:2]);         // see [R15]
        end else if (clk_en && word_new) begin
            cfg_q <= word_cfg;                                  // see [R14]
        end
    end

    // ------------------------------------------------------------
    // zero-cross toggle and revolution pulse source
    // ------------------------------------------------------------
    logic zc_tgl_q;
    logic rev_q;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            zc_tgl_q <= 1'b0;
            rev_q    <= 1'b0;
        end else if (clk_en) begin
            if (zc_rise) begin
                zc_tgl_q <= ~zc_tgl_q;                          // see [R13]
            end
            if (cfg_q.sector_mode ? sec_rise : (zc_rise && zc_tgl_q)) begin
                rev_q <= ~rev_q;                                // see [R10]
            end
        end
    end

    // ------------------------------------------------------------
    // speed reference counter on oscillator edges
    // ------------------------------------------------------------
    logic [SPEED_CNT_W-1:0] ref_total;
    always_comb begin
        ref_total = SPEED_CNT_RESET;
        for (int i = 0; i < SPEED_BITS; i++) begin
            if (!cfg_q.speed_count[i]) begin
                ref_total = ref_total + SPEED_CNT_W'(1 << i);    // see [R12]
            end
        end
    end

    logic [SPEED_CNT_W-1:0] ref_cnt_q;
    logic                   ref_q;
    logic                   rev_prev_q;
    wire rev_edge = rev_q & ~rev_prev_q;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ref_cnt_q  <= SPEED_CNT_RESET;
            ref_q      <= 1'b0;
            rev_prev_q <= 1'b0;
        end else if (clk_en) begin
            rev_prev_q <= rev_q;
            if (rev_edge && ref_total != SPEED_CNT_RESET) begin
                ref_q     <= 1'b1;
                ref_cnt_q <= ref_total;
            end else if (ref_q && osc_rise) begin
                ref_cnt_q <= ref_cnt_q - SPEED_CNT_W'(1);        // see [R9]
                if (ref_cnt_q == SPEED_CNT_W'(1)) begin
                    ref_q <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // commutation sequencer
    // ------------------------------------------------------------
    phase_t phase_q;
    phase_t phase_fwd;
    phase_t phase_rev;
    always_comb begin
        case (phase_q)
            PH0: begin phase_fwd = PH1; phase_rev = PH5; end
            PH1: begin phase_fwd = PH2; phase_rev = PH0; end
            PH2: begin phase_fwd = PH3; phase_rev = PH1; end
            PH3: begin phase_fwd = PH4; phase_rev = PH2; end
            PH4: begin phase_fwd = PH5; phase_rev = PH3; end
            PH5: begin phase_fwd = PH0; phase_rev = PH4; end
            default: begin phase_fwd = PH0; phase_rev = PH0; end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            phase_q <= PHASE_RESET;
        end else if (clk_en && commutate_evt) begin
            phase_q <= cfg_q.direction_bit ? phase_rev : phase_fwd;   // see [R11]
        end
    end

    // ------------------------------------------------------------
    // output drive, sleep, diag mux
    // ------------------------------------------------------------
    wire    awake = cfg_q.run;
    drive_t drive_run;
    always_comb begin
        case (phase_q)
            PH0: drive_run = 6'b100_010;
            PH1: drive_run = 6'b001_010;
            PH2: drive_run = 6'b001_100;
            PH3: drive_run = 6'b010_100;
            PH4: drive_run = 6'b010_001;
            PH5: drive_run = 6'b100_001;
            default: drive_run = 6'b000_000;
        endcase
    end

    wire    brake_any = brake_on | cfg_q.brake;
    drive_t drive_d;
    assign drive_d = brake_any ? 6'b000_111 :                            // see [R8]
                     (awake ? drive_run : 6'b000_000);
    logic   diag_d;
    assign diag_d = (cfg_q.diag_sel == DIAG_THERMAL) ? thermal_shutdown :
                    (cfg_q.diag_sel == DIAG_ZCROSS)  ? zc_tgl_q :
                    (cfg_q.diag_sel == DIAG_REV)     ? rev_q : sync_flag;  // see [R6]

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sleep    <= 1'b1;                                   // see [R4]
            drive    <= 6'b000_000;                             // see [R15]
            diag_out <= 1'b0;
        end else if (clk_en) begin
            sleep    <= ~awake;
            drive    <= drive_d;
            diag_out <= diag_d;
        end
    end

    assign current_limit     = cfg_q.current_limit;              // see [R7]
    assign speed_ref         = ref_q;
    assign revolution_pulse  = rev_q;
    assign zero_cross_toggle = zc_tgl_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_brake_lowside: assert property (@(posedge sys_clk) disable iff (!rstn) // see [R8]
        (clk_en && brake_on) |=> drive.low_a && drive.low_b && drive.low_c)
        else $error("brake did not enable all low sides");
    chk_diag_mux_route: assert property (@(posedge sys_clk) disable iff (!rstn) // see [R6]
        (clk_en && cfg_q.diag_sel == DIAG_ZCROSS) |=> diag_out == $past(zc_tgl_q))
        else $error("diag output not routed");
    chk_zc_toggle: assert property (@(posedge sys_clk) disable iff (!rstn) // see [R13]
        (clk_en && zc_rise) |=> zc_tgl_q != $past(zc_tgl_q))
        else $error("zero-cross toggle missed");
    chk_dir_order: assert property (@(posedge sys_clk) disable iff (!rstn) // see [R11]
        (clk_en && commutate_evt && !cfg_q.direction_bit && phase_q == PH0) |=> phase_q == PH1)
        else $error("forward order wrong");
    chk_dir_reverse: assert property (@(posedge sys_clk) disable iff (!rstn) // see [R11]
        (clk_en && commutate_evt && cfg_q.direction_bit && phase_q == PH0) |=> phase_q == PH5)
        else $error("reverse order wrong");
    chk_sleep_follows: assert property (@(posedge sys_clk) disable iff (!rstn) // see [R15]
        clk_en |=> sleep == !$past(cfg_q.run))
        else $error("sleep not tracking run");
    chk_word_whole: assert property (@(posedge sys_clk) disable iff (!rstn) // see [R14]
        (clk_en && !word_new) |=> $stable(cfg_q))
        else $error("config changed without word");
    chk_ref_load: assert property (@(posedge sys_clk) disable iff (!rstn) // see [R12]
        (clk_en && rev_edge && ref_total != SPEED_CNT_RESET) |=> ref_q && ref_cnt_q == $past(ref_total))
        else $error("reference not loaded");
    chk_ilim_map: assert property (@(posedge sys_clk) disable iff (!rstn) // see [R7]
        (clk_en && word_new) |=> current_limit == {$past(word_q[ILIM_HI_POS]), $past(word_q[ILIM_LO_POS])})
        else $error("current limit mismatch");
    chk_shift_bit: assert property (@(posedge port_clk) disable iff (!rstn) // see [R1]
        !chip_sel_n |=> shift_q[0] == $past(data_in))
        else $error("serial bit not captured");

    cov_word_loaded: cover property (@(posedge sys_clk) disable iff (!rstn) clk_en && word_new);
    cov_brake: cover property (@(posedge sys_clk) disable iff (!rstn) brake_on);
    cov_ref_done: cover property (@(posedge sys_clk) disable iff (!rstn) $fell(ref_q));
endmodule

// >>> host_serial_model.sv
/*
 * Host side of the serial configuration port: frames one 24-bit word per call.
 * Assumes the caller spaces frames by at least 8 core clock cycles.
 */
`timescale 1ns/100ps

module host_serial_model (
    output logic port_clk,
    output logic chip_sel_n,
    output logic data_in
);
    initial begin
        port_clk   = 1'b0;
        chip_sel_n = 1'b1;
        data_in    = 1'b0;
    end

    // ------------------------------------------------------------
    // one frame, msb first, link clock only runs inside the frame
    // ------------------------------------------------------------
    task automatic send_word(input logic [23:0] w);
        int i;
        port_clk = 1'b0;
        #7.5 chip_sel_n = 1'b0;
        for (i = 23; i >= 0; i--) begin
            data_in = w[i];
            #7.5 port_clk = 1'b1;
            #7.5 port_clk = 1'b0;
        end
        #7.5 chip_sel_n = 1'b1;
        // released line shows the inverse of its last bit
        data_in = ~w[0];
    endtask
endmodule

// >>> motor_cfg_port_tb.sv
/*
 * Self-checking bench for motor_cfg_port with a host serial model.
 * Assumes the design's own assertions guard cycle relations.
 */
`timescale 1ns/100ps

module motor_cfg_port_tb;
    import motor_cfg_pkg::*;

    logic   sys_clk = 1'b0;
    logic   rstn = 1'b1;
    logic   clk_en = 1'b1;
    logic   osc_in = 1'b0;
    logic   sector_in = 1'b0;
    logic   brake_n = 1'b1;
    logic   zero_cross_evt = 1'b0;
    logic   commutate_evt = 1'b0;
    logic   thermal_shutdown = 1'b0;
    logic   sync_flag = 1'b0;
    wire    port_clk;
    wire    chip_sel_n;
    wire    data_in;
    logic   sleep;
    drive_t drive;
    ilim_t  current_limit;
    logic   diag_out;
    logic   speed_ref;
    logic   revolution_pulse;
    logic   zero_cross_toggle;
    int     error_cnt = 0;
    int     checks_done = 0;
    int     k;
    logic   old_v;
    drive_t d1;

    always #25 sys_clk = ~sys_clk;

    host_serial_model host (.port_clk(port_clk), .chip_sel_n(chip_sel_n), .data_in(data_in));

    motor_cfg_port DUT (
        .sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en), .port_clk(port_clk),
        .chip_sel_n(chip_sel_n), .data_in(data_in), .osc_in(osc_in), .sector_in(sector_in),
        .brake_n(brake_n), .zero_cross_evt(zero_cross_evt), .commutate_evt(commutate_evt),
        .thermal_shutdown(thermal_shutdown), .sync_flag(sync_flag), .sleep(sleep),
        .drive(drive), .current_limit(current_limit), .diag_out(diag_out),
        .speed_ref(speed_ref), .revolution_pulse(revolution_pulse),
        .zero_cross_toggle(zero_cross_toggle)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    function automatic logic [23:0] mk(logic run, logic [1:0] dsel, logic sect, logic [13:0] spd,
                                       logic [1:0] ilim, logic dir);
        // current-limit code msb travels at bit 3, lsb at bit 4
        return {run, 1'b0, dsel, sect, spd, ilim[0], ilim[1], dir, 2'b00};
    endfunction

    task automatic cfg(input logic [23:0] w);
        host.send_word(w);
        tick(8);
    endtask

    task automatic pulse(input int which);
        case (which)
            0: zero_cross_evt <= 1'b1;
            1: sector_in <= 1'b1;
            default: osc_in <= 1'b1;
        endcase
        tick(4);
        zero_cross_evt <= 1'b0;
        sector_in <= 1'b0;
        osc_in <= 1'b0;
        tick(4);
    endtask

    task automatic step();
        commutate_evt <= 1'b1;
        tick(1);
        commutate_evt <= 1'b0;
        tick(3);
    endtask

    // sel 0 watches speed_ref, sel 1 the phase a sink driver
    task automatic wait_bit(input int sel, input logic lvl);
        int i;
        for (i = 0; i < 40 && (sel ? drive.low_a : speed_ref) !== lvl; i++)
            tick(1);
        if (i == 40) begin
            error_cnt++;
            complete_run();
        end
    endtask

    task automatic do_reset();
        rstn <= 1'b0;
        tick(12);
        cmp(24'(sleep), 24'h000001);
        cmp(24'(current_limit), 24'h000000);
        cmp(24'(drive), 24'h000000);
        cmp(24'(diag_out), 24'h000000);
        rstn <= 1'b1;
        tick(2);
        cmp(24'(sleep), 24'h000001);
        cmp(24'(current_limit), 24'h000000);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        #2ms;
        error_cnt++;
        complete_run();
    end

    initial begin
        do_reset();
        $display("test reset done");
        for (k = 0; k < 4; k++) begin
            cfg(mk(1'b1, 2'h0, 1'b0, 14'h3fff, 2'(k), 1'b0));
            cmp(24'(current_limit), 24'(k));
            cmp(24'(sleep), 24'h000000);
        end
        $display("test current limit done");
        do_reset();
        cfg(mk(1'b1, DIAG_THERMAL, 1'b0, 14'h3fff, 2'h0, 1'b0));
        thermal_shutdown <= 1'b1;
        tick(3);
        cmp(24'(diag_out), 24'h000001);
        cfg(mk(1'b1, DIAG_SYNC, 1'b0, 14'h3fff, 2'h0, 1'b0));
        cmp(24'(diag_out), 24'h000000);
        sync_flag <= 1'b1;
        tick(3);
        cmp(24'(diag_out), 24'h000001);
        cfg(mk(1'b1, DIAG_ZCROSS, 1'b0, 14'h3fff, 2'h0, 1'b0));
        old_v = zero_cross_toggle;
        pulse(0);
        cmp(24'(zero_cross_toggle), {23'h0, ~old_v});
        cmp(24'(diag_out), {23'h0, ~old_v});
        cfg(mk(1'b1, DIAG_REV, 1'b0, 14'h3fff, 2'h0, 1'b0));
        pulse(0);
        cmp(24'(diag_out), 24'h000001);
        $display("test diag select done");
        cfg(mk(1'b1, DIAG_REV, 1'b1, 14'h3ffc, 2'h0, 1'b0));
        old_v = revolution_pulse;
        pulse(1);
        cmp(24'(revolution_pulse), {23'h0, ~old_v});
        if (revolution_pulse !== 1'b0)
            pulse(1);
        pulse(1);
        wait_bit(0, 1'b1);
        pulse(2);
        pulse(2);
        cmp(24'(speed_ref), 24'h000001);
        pulse(2);
        wait_bit(0, 1'b0);
        cmp(24'(speed_ref), 24'h000000);
        $display("test speed reference done");
        step();
        d1 = drive;
        cmp(24'(drive), 24'h00000a);
        step();
        cmp(24'(drive), 24'h00000c);
        cfg(mk(1'b1, DIAG_REV, 1'b1, 14'h3ffc, 2'h0, 1'b1));
        step();
        cmp(24'(drive), 24'(d1));
        $display("test direction done");
        brake_n <= 1'b0;
        wait_bit(1, 1'b1);
        cmp(24'(drive), 24'h000007);
        brake_n <= 1'b1;
        tick(6);
        cmp(24'(drive), 24'h00000a);
        $display("test brake done");
        clk_en <= 1'b0;
        cfg(mk(1'b1, DIAG_REV, 1'b0, 14'h3fff, 2'h1, 1'b0));
        cmp(24'(current_limit), 24'h000000);
        clk_en <= 1'b1;
        tick(8);
        cmp(24'(current_limit), 24'h000001);
        $display("test clock enable done");
        cfg(mk(1'b1, DIAG_REV, 1'b0, 14'h0000, 2'h3, 1'b0));
        cmp(24'(current_limit), 24'h000003);
        do_reset();
        $display("test mid-run reset done");
        complete_run();
    end
endmodule
